// *** verilog/l2_proc_bus_invalidate_burst.sv ***
// processor-bus side: primary invalidate snoops and four-beat burst service
// assumes processor inputs are on clk_sys; grant and retry come from pins
`timescale 1ns/1ps
module l2_proc_bus_invalidate_burst #(
  parameter int ADDR_W = l2_proc_bus_pkg::ADDR_W,
  parameter int BEATS = l2_proc_bus_pkg::BEATS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  // invalidate requests from the snoop logic
  input wire logic invReq,
  input wire logic invDma,
  input wire logic [ADDR_W-1:0] invAddr,
  output logic invBusy,
  output logic invDone,
  output logic invRetried,
  // processor bus arbitration
  output logic busRequest,
  input wire logic busGrant,
  // processor bus transfer signals
  input wire logic [ADDR_W-1:0] procAddrIn,
  output logic [ADDR_W-1:0] procAddrOut,
  output logic procAddrOe,
  input wire logic transferStartIn,
  output logic transferStartOut,
  input wire logic burstIndicatorIn,
  output logic burstIndicatorOut,
  input wire logic readNotWrite,
  output logic globalSnoopAttr,
  output logic invalidateAttr,
  output logic attrOe,
  output logic addressBusBusyOut,
  input wire logic addressRetry,
  output logic transferAcknowledge,
  output logic preTransferAck,
  input wire logic transferErrorAck,
  input wire logic transferRetry,
  // tag lookup and data readiness from the cache core
  input wire logic tagHit,
  input wire logic missDataReady,
  output logic burstActive,
  output logic burstDone,
  // cache RAM array port
  output logic [ADDR_W-1:0] ramAddr,
  output logic ramAddrOe,
  output logic procSideOutputEnable,
  output logic procSideInputEnable,
  output logic [7:0] ramWriteEnables
);
  l2_proc_bus_pkg::state_type state_q, state_d;
  logic [1:0] grantSync_q, retrySync_q;
  logic [ADDR_W-1:0] addr_q;
  logic dma_q, read_q, hit_q, tsPulse_q;
  logic [l2_proc_bus_pkg::BEAT_W-1:0] beatCnt_q;
  logic [l2_proc_bus_pkg::SNOOP_CNT_W-1:0] snoopCnt_q;
  logic beatValid, beatOk, lastBeat, startBurst;
  localparam int DW_MSB = l2_proc_bus_pkg::DW_LSB + l2_proc_bus_pkg::BEAT_W - 1;

  // grant comes from the external arbiter pin
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      grantSync_q <= 2'h0;
    end else begin
      grantSync_q <= {grantSync_q[0], busGrant};
    end
  end

  // address retry is a pin as well
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      retrySync_q <= 2'h0;
    end else begin
      retrySync_q <= {retrySync_q[0], addressRetry};
    end
  end

  // burst start and beat qualification
  always_comb begin
    startBurst = transferStartIn && burstIndicatorIn
      && (state_q == l2_proc_bus_pkg::ST_IDLE);
    beatValid = (state_q == l2_proc_bus_pkg::ST_BURST_BEAT)
      && (hit_q || missDataReady);
    beatOk = beatValid && !transferErrorAck
      && !transferRetry; // RULE23
    lastBeat = (beatCnt_q == l2_proc_bus_pkg::BEAT_W'(BEATS - 1));
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      l2_proc_bus_pkg::ST_IDLE: begin
        if (startBurst) begin
          state_d = l2_proc_bus_pkg::ST_BURST_LOOK;
        end else if (invReq) begin
          state_d = l2_proc_bus_pkg::ST_INV_REQ;
        end
      end
      l2_proc_bus_pkg::ST_INV_REQ: begin
        if (grantSync_q[1]) begin
          state_d = l2_proc_bus_pkg::ST_INV_ADDR; // RULE1
        end
      end
      l2_proc_bus_pkg::ST_INV_ADDR: begin
        state_d = l2_proc_bus_pkg::ST_INV_SNOOP;
      end
      l2_proc_bus_pkg::ST_INV_SNOOP: begin
        if (retrySync_q[1]) begin
          state_d = l2_proc_bus_pkg::ST_RELEASE;
        end else if (snoopCnt_q == l2_proc_bus_pkg::SNOOP_CNT_W'(l2_proc_bus_pkg::SNOOP_DELAY)) begin
          state_d = l2_proc_bus_pkg::ST_RELEASE; // RULE7 RULE24
        end
      end
      l2_proc_bus_pkg::ST_BURST_LOOK: begin
        state_d = l2_proc_bus_pkg::ST_BURST_BEAT; // RULE15
      end
      l2_proc_bus_pkg::ST_BURST_BEAT: begin
        if (beatOk && lastBeat) begin
          state_d = l2_proc_bus_pkg::ST_RELEASE; // RULE12
        end else if (beatValid && !beatOk) begin
          state_d = l2_proc_bus_pkg::ST_RELEASE;
        end
      end
      l2_proc_bus_pkg::ST_RELEASE: begin
        state_d = l2_proc_bus_pkg::ST_IDLE; // RULE21
      end
      default: state_d = l2_proc_bus_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= l2_proc_bus_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // line address: taken from the processor or the snoop side, then stepped per beat
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      addr_q <= '0;
    end else if (state_q == l2_proc_bus_pkg::ST_IDLE) begin
      if (startBurst) begin
        addr_q <= procAddrIn; // RULE10 RULE11
      end else if (invReq) begin
        addr_q <= invAddr;
      end
    end else if (beatOk) begin
      // only the double-word field moves, so the burst wraps inside its line
      addr_q[DW_MSB:l2_proc_bus_pkg::DW_LSB] <= addr_q[DW_MSB:l2_proc_bus_pkg::DW_LSB]
        + l2_proc_bus_pkg::BEAT_W'(1); // RULE10 RULE12 RULE20
    end
  end

  // burst direction and invalidate flavour
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      read_q <= 1'b0;
      dma_q <= 1'b0;
    end else if (state_q == l2_proc_bus_pkg::ST_IDLE) begin
      if (startBurst) begin
        read_q <= readNotWrite;
      end else if (invReq) begin
        dma_q <= invDma;
      end
    end
  end

  // lookup result, held for the whole burst
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hit_q <= 1'b0;
    end else if (state_q == l2_proc_bus_pkg::ST_BURST_LOOK) begin
      hit_q <= tagHit;
    end
  end

  // beat counter and snoop delay counter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      beatCnt_q <= '0;
    end else if (state_q != l2_proc_bus_pkg::ST_BURST_BEAT) begin
      beatCnt_q <= '0;
    end else if (beatOk) begin
      beatCnt_q <= beatCnt_q + l2_proc_bus_pkg::BEAT_W'(1); // RULE9
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      snoopCnt_q <= '0;
    end else if (state_q == l2_proc_bus_pkg::ST_INV_SNOOP) begin
      snoopCnt_q <= snoopCnt_q + l2_proc_bus_pkg::SNOOP_CNT_W'(1);
    end else begin
      snoopCnt_q <= '0;
    end
  end

  // one-clock start strobe for the invalidate
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tsPulse_q <= 1'b0;
    end else begin
      tsPulse_q <= (state_d == l2_proc_bus_pkg::ST_INV_ADDR)
        && (state_q == l2_proc_bus_pkg::ST_INV_REQ); // RULE5
    end
  end

  // pre-transfer acknowledge one clock after a burst start
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      preTransferAck <= 1'b0;
    end else begin
      preTransferAck <= startBurst; // RULE17
    end
  end

  // clean end of the snoop window
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      invDone <= 1'b0;
    end else begin
      invDone <= (state_q == l2_proc_bus_pkg::ST_INV_SNOOP) && !retrySync_q[1]
        && (state_d == l2_proc_bus_pkg::ST_RELEASE); // RULE7
    end
  end

  // processor claimed the line for a copyback
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      invRetried <= 1'b0;
    end else begin
      invRetried <= (state_q == l2_proc_bus_pkg::ST_INV_SNOOP) && retrySync_q[1]; // RULE6
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      burstDone <= 1'b0;
    end else begin
      burstDone <= beatOk && lastBeat;
    end
  end

  assign procAddrOut = addr_q; // RULE3
  assign ramAddr = addr_q; // RULE11
  assign transferStartOut = tsPulse_q; // RULE5
  // acknowledge only on valid beats; none for invalidates
  assign transferAcknowledge = beatValid; // RULE4 RULE13 RULE16 RULE22

  // bus ownership and enables follow the state directly
  always_comb begin
    invBusy = 1'b0;
    busRequest = 1'b0;
    procAddrOe = 1'b0;
    addressBusBusyOut = 1'b0;
    attrOe = 1'b0;
    globalSnoopAttr = 1'b0;
    invalidateAttr = 1'b0;
    burstIndicatorOut = 1'b0;
    burstActive = 1'b0;
    ramAddrOe = 1'b0;
    procSideOutputEnable = 1'b0;
    procSideInputEnable = 1'b0;
    case (state_q)
      l2_proc_bus_pkg::ST_IDLE: begin
        invBusy = 1'b0;
      end
      l2_proc_bus_pkg::ST_INV_REQ: begin
        invBusy = 1'b1;
        busRequest = 1'b1; // RULE1
      end
      l2_proc_bus_pkg::ST_INV_ADDR: begin
        invBusy = 1'b1;
        procAddrOe = 1'b1; // RULE24
        addressBusBusyOut = 1'b1; // RULE24
        attrOe = 1'b1;
        globalSnoopAttr = 1'b1; // RULE3
        invalidateAttr = 1'b1; // RULE3
        burstIndicatorOut = dma_q; // RULE8
      end
      l2_proc_bus_pkg::ST_INV_SNOOP: begin
        invBusy = 1'b1;
        procAddrOe = 1'b1; // RULE24
        addressBusBusyOut = 1'b1; // RULE24
        attrOe = 1'b1;
        globalSnoopAttr = 1'b1; // RULE3
        invalidateAttr = 1'b1; // RULE3
        burstIndicatorOut = dma_q; // RULE8
      end
      l2_proc_bus_pkg::ST_BURST_LOOK: begin
        burstActive = 1'b1;
        ramAddrOe = 1'b1; // RULE21
        procSideOutputEnable = read_q; // RULE19
        procSideInputEnable = !read_q;
      end
      l2_proc_bus_pkg::ST_BURST_BEAT: begin
        burstActive = 1'b1;
        ramAddrOe = 1'b1; // RULE21
        procSideOutputEnable = read_q; // RULE19
        procSideInputEnable = !read_q;
      end
      l2_proc_bus_pkg::ST_RELEASE: begin
        // everything released, acknowledge already low
        burstActive = 1'b0; // RULE21
      end
      default: begin
        invBusy = 1'b0;
      end
    endcase
  end

  // every byte lane of the RAM is enabled on a read beat
  genvar lane;
  generate
    for (lane = 0; lane < 8; lane = lane + 1) begin : g_rwe
      assign ramWriteEnables[lane] = beatValid && read_q; // RULE20
    end
  endgenerate
endmodule

// *** verilog/l2_proc_bus_pkg.sv ***
// constants for the processor-bus invalidate and burst block
// assumes a single 125 MHz bus clock shared with the processor and RAM array
//
// Functional notes
// [RULE1] invalidate waits for processor bus grant through normal arbitration.
// [RULE2] external arbiter should favour the cache controller over the processor.
// [RULE3] invalidate drives line address with global and invalidate attributes asserted.
// [RULE4] invalidate is address only: no data, no acknowledge expected.
// [RULE5] transfer start strobe lasts exactly one clock for an invalidate.
// [RULE6] processor retries only on modified hit, then copies the line back.
// [RULE7] no address retry within two-clock snoop delay means invalidate done.
// [RULE8] DMA invalidate asserts burst indicator; processor drops line without copyback.
// [RULE9] burst moves exactly four double words.
// [RULE10] burst starts at addressed double word and wraps within the line.
// [RULE11] RAM addresses for later beats come from an internal counter.
// [RULE12] acknowledge each valid beat, advance address, end after fourth beat.
// [RULE13] acknowledge stays negated while data is not ready.
// [RULE14] processor holds its address while acknowledge is negated.
// [RULE15] second clock of a burst is a wait state for tag lookup.
// [RULE16] on hit first beat in clock 3, rest in following consecutive clocks.
// [RULE17] pre-transfer acknowledge comes exactly one clock after start strobe.
// [RULE18] processor starts burst with address, attributes, start strobe and burst.
// [RULE19] read hit enables the RAM output toward the processor in clock 2.
// [RULE20] first read beat: acknowledge, advance address, assert RAM write enables.
// [RULE21] after fourth beat outputs release in clock 7 and acknowledge drops.
// [RULE22] on a miss acknowledge waits until data becomes available.
// [RULE23] a beat counts when acknowledge is high with error and retry low.
// [RULE24] keep bus mastership for invalidate until snoop window closes cleanly.
package l2_proc_bus_pkg;
  localparam int ADDR_W = 32;
  localparam int BEATS = 4;
  localparam int BEAT_W = 2;
  localparam int DW_LSB = 3;
  localparam int SNOOP_DELAY = 2;
  localparam int SNOOP_CNT_W = 2;
  localparam logic [7:0] RWE_ALL = 8'hFF;
  localparam logic [7:0] RWE_NONE = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_INV_REQ = 3'b001,
    ST_INV_ADDR = 3'b010,
    ST_INV_SNOOP = 3'b011,
    ST_BURST_LOOK = 3'b100,
    ST_BURST_BEAT = 3'b101,
    ST_RELEASE = 3'b110
  } state_type;
endpackage

// *** dv/l2_proc_bus_checker.sv ***
// port assertions for the burst and invalidate block
// bound to the block top; single clock domain
`timescale 1ns/1ps
module l2_proc_bus_checker #(
  parameter int ADDR_W = 32
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic transferStartIn,
  input wire logic burstIndicatorIn,
  input wire logic readNotWrite,
  input wire logic tagHit,
  input wire logic missDataReady,
  input wire logic preTransferAck,
  input wire logic transferAcknowledge,
  input wire logic procSideOutputEnable,
  input wire logic [7:0] ramWriteEnables,
  input wire logic [ADDR_W-1:0] ramAddr,
  input wire logic ramAddrOe,
  input wire logic burstActive,
  input wire logic invBusy,
  input wire logic invDma,
  input wire logic transferStartOut,
  input wire logic globalSnoopAttr,
  input wire logic invalidateAttr,
  input wire logic burstIndicatorOut,
  input wire logic invDone,
  input wire logic invRetried
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic missQ;
  // remembers a lookup miss for the rest of the burst
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      missQ <= 1'b0;
    end else if (preTransferAck) begin
      missQ <= !tagHit;
    end
  end
  sequence start_s;
    transferStartIn && burstIndicatorIn && !burstActive && !invBusy;
  endsequence
  chk_pta_one_clock: assert property (start_s |=> preTransferAck ##1 !preTransferAck)
    else $error("pre-transfer ack misplaced");
  chk_lookup_wait: assert property (start_s and readNotWrite |=>
    procSideOutputEnable && !transferAcknowledge) else $error("lookup cycle wrong");
  chk_hit_beats: assert property (start_s ##1 tagHit |=>
    transferAcknowledge [*4] ##1 !transferAcknowledge) else $error("hit beats wrong");
  chk_rwe_read_beat: assert property (transferAcknowledge && procSideOutputEnable |->
    ramWriteEnables == l2_proc_bus_pkg::RWE_ALL) else $error("write enables off");
  chk_addr_wrap: assert property (transferAcknowledge ##1 transferAcknowledge |->
    ramAddr[4:3] == $past(ramAddr[4:3]) + 2'h1 && $stable(ramAddr[ADDR_W-1:5]))
    else $error("ram address step wrong");
  chk_release_outputs: assert property (transferAcknowledge [*4] ##1 !transferAcknowledge |->
    !ramAddrOe && !procSideOutputEnable && ramWriteEnables == l2_proc_bus_pkg::RWE_NONE)
    else $error("outputs not released");
  chk_miss_hold: assert property (burstActive && missQ && !missDataReady |->
    !transferAcknowledge) else $error("ack before miss data");
  chk_inv_start: assert property (transferStartOut |-> (globalSnoopAttr && invalidateAttr &&
    burstIndicatorOut == invDma) ##1 !transferStartOut) else $error("invalidate start wrong");
  chk_inv_no_ack: assert property (invBusy |-> !transferAcknowledge)
    else $error("ack during invalidate");
  chk_inv_ends: assert property (transferStartOut |-> ##[2:8] (invDone || invRetried))
    else $error("invalidate never ended");
  cover property (start_s ##1 tagHit);
  cover property (start_s ##1 !tagHit);
  cover property (invRetried);
endmodule

// *** dv/proc_core_model.sv ***
// processor model: bus arbiter, burst starter, snoop responder
// driven by the bench through go and retryOn
`timescale 1ns/1ps
module proc_core_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic go,
  input wire logic [31:0] goAddr,
  input wire logic goRead,
  input wire logic retryOn,
  input wire logic busRequest,
  input wire logic transferStartOut,
  input wire logic burstIndicatorOut,
  input wire logic transferAcknowledge,
  output logic [31:0] procAddrIn,
  output logic transferStartIn,
  output logic burstIndicatorIn,
  output logic readNotWrite,
  output logic busGrant,
  output logic addressRetry
);
  logic snoopQ;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {procAddrIn, transferStartIn, burstIndicatorIn, readNotWrite} <= 35'h0;
      {busGrant, addressRetry, snoopQ} <= 3'h0;
    end else begin
      busGrant <= busRequest;
      transferStartIn <= go;
      burstIndicatorIn <= go;
      // modified hit retries, a DMA invalidate never does
      snoopQ <= transferStartOut && retryOn && !burstIndicatorOut;
      addressRetry <= (transferStartOut && retryOn && !burstIndicatorOut) || snoopQ;
      if (go) begin
        procAddrIn <= goAddr;
        readNotWrite <= goRead;
      end else if (transferAcknowledge) begin
        procAddrIn <= procAddrIn + 32'h8;
      end
    end
  end
endmodule

// *** dv/testbench.sv ***
// bench: bursts and primary invalidates against the processor model
// one clock at 125 MHz; reset held five clocks
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0, rstn = 1'b0, invReq = 1'b0, invDma = 1'b0, tagHit = 1'b0, go = 1'b0;
  logic missDataReady = 1'b0, goRead = 1'b0, retryOn = 1'b0;
  logic transferErrorAck = 1'b0, transferRetry = 1'b0;
  logic [31:0] invAddr = 32'h0, goAddr = 32'h0, procAddrIn, procAddrOut, ramAddr;
  logic invBusy, invDone, invRetried, busRequest, busGrant, procAddrOe, transferStartIn;
  logic transferStartOut, burstIndicatorIn, burstIndicatorOut, readNotWrite, globalSnoopAttr;
  logic invalidateAttr, attrOe, addressBusBusyOut, addressRetry, transferAcknowledge;
  logic preTransferAck, burstActive, burstDone, ramAddrOe, procSideOutputEnable;
  logic procSideInputEnable;
  logic [7:0] ramWriteEnables;
  int errors = 0;
  int checkCount = 0;
  always #4 clk_sys = ~clk_sys;
  l2_proc_bus_invalidate_burst i_l2_proc_bus_invalidate_burst (.*);
  proc_core_model i_proc_core_model (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", errors, checkCount);
    if (errors == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  // pat marks the cycles after the start that must carry a beat acknowledge
  task automatic burst(input logic [31:0] a, input logic rd, input logic hit,
                       input logic [11:0] pat);
    int n;
    n = 0;
    {goAddr, goRead, tagHit, go} = {a, rd, hit, 1'b1};
    tick();
    go = 1'b0;
    for (int i = 1; i < 12; i++) begin
      tick();
      missDataReady = !hit && pat[i];
      #1;
      check(transferAcknowledge, pat[i]);
      check(preTransferAck, i == 1);
      if (i == 1) check(procSideOutputEnable, rd);
      if (i == 1) check({burstActive, procSideInputEnable}, {1'b1, !rd});
      check(burstDone, pat[i-1] && n == 4);
      if (hit && i == 6) check({ramAddrOe, procSideOutputEnable}, 2'h0);
      if (transferAcknowledge === 1'b1) begin
        check(ramAddr[31:3], {a[31:5], a[4:3] + n[1:0]});
        if (rd) check(ramWriteEnables, 8'hFF);
        n++;
      end
    end
    check(n, 4);
  endtask
  task automatic inv(input logic dma, input logic rt, input logic [31:0] a);
    int k;
    {invDma, retryOn, invAddr, invReq} = {dma, rt, a, 1'b1};
    for (k = 0; k < 40 && invDone !== 1'b1 && invRetried !== 1'b1; k++) begin
      tick();
      invReq = 1'b0;
      #1;
      if (transferStartOut === 1'b1) begin
        check(procAddrOut, a);
        check({busGrant, globalSnoopAttr, invalidateAttr, burstIndicatorOut}, {3'h7, dma});
        check(transferAcknowledge, 1'b0);
        check({procAddrOe, attrOe, addressBusBusyOut, invBusy}, 4'hF);
      end
    end
    if (k == 40) begin
      errors++;
      test_done();
    end
    check(invRetried, rt && !dma);
    check(invDone, !(rt && !dma));
    repeat (4) tick();
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    tick();
    burst(32'h0000_1018, 1'b1, 1'b1, 12'h03C);
    burst(32'h0000_2000, 1'b0, 1'b1, 12'h03C);
    burst(32'h0000_3008, 1'b1, 1'b0, 12'h268);
    inv(1'b0, 1'b0, 32'h0000_4020);
    inv(1'b0, 1'b1, 32'h0000_5040);
    inv(1'b1, 1'b1, 32'h0000_6060);
    test_done();
  end
endmodule
bind l2_proc_bus_invalidate_burst l2_proc_bus_checker #(.ADDR_W(ADDR_W)) i_l2_proc_bus_checker (.*);
